// [core/secreg_consts.svh]
`ifndef SECREG_CONSTS_SVH
`define SECREG_CONSTS_SVH

// System clock rate used for every time-to-cycle conversion
`define CLK_MHZ 125

// Instruction codes handled by this block
`define CMD_STATUS_LO 8'h05
`define CMD_STATUS_HI 8'h35
`define CMD_STATUS_INT 8'h25
`define CMD_RESET_ARM 8'h66
`define CMD_RESET_GO 8'h99
`define CMD_RESUME 8'h7A
`define CMD_WRITE_ON 8'h06
`define CMD_WRITE_OFF 8'h04
`define CMD_SEC_ERASE 8'h44
`define CMD_SEC_PROG 8'h42
`define CMD_SEC_READ 8'h48

// Serial-clock rising edges that close each frame section, and the value at which the bit count stops
`define OPCODE_BITS 6'h08
`define ADDR_END_BITS 6'h20
`define READ_DATA_BITS 6'h28
`define BITCNT_MAX 6'h3F

// Security register address fields
`define ADDR_TOP_MSB 23
`define ADDR_TOP_LSB 16
`define ADDR_SEL_MSB 15
`define ADDR_SEL_LSB 12
`define ADDR_GAP_MSB 11
`define ADDR_GAP_LSB 9
`define SECREG_FIRST 4'h1
`define SECREG_LAST 4'h3
`define SECREG_BYTES 512
`define SECREG_COUNT 3
`define ERASED_BYTE 8'hFF

// Status word bit positions
`define STAT_WIP 0
`define STAT_WEL 1
`define STAT_ERASE_SUS 10
`define STAT_LOCK_LSB 11
`define STAT_PROG_SUS 15

// Timing: times in ns, cycles derived from the clock rate
`define RESUME_WIP_NS 200
`define RESUME_WIP_CYC ((`RESUME_WIP_NS * `CLK_MHZ) / 1000)
`define SECREG_ERASE_NS 50000
`define SECREG_ERASE_CYC ((`SECREG_ERASE_NS * `CLK_MHZ + 999) / 1000)
`define SECREG_PROG_NS 20000
`define SECREG_PROG_CYC ((`SECREG_PROG_NS * `CLK_MHZ + 999) / 1000)
`define RESET_RECOVERY_NS 30000
`define RESET_RECOVERY_CYC ((`RESET_RECOVERY_NS * `CLK_MHZ + 999) / 1000)

`endif

// [core/flash_pkg.sv]
package flash_pkg;

    // Position within one chip-select frame
    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_CMD = 5'h02,
        PH_ADDR = 5'h04,
        PH_DATA = 5'h08,
        PH_SKIP = 5'h10
    } phase_type;

    // Self-timed background activity
    typedef enum logic [3:0] {
        OP_NONE = 4'h1,
        OP_WALK = 4'h2,
        OP_WAIT = 4'h4,
        OP_RECOVER = 4'h8
    } op_type;

    typedef struct packed {
        logic write_in_progress;
        logic write_enable_latch;
        logic suspend_flag;
        logic program_suspended_flag;
        logic erase_suspended_flag;
    } flash_status_type;

    typedef struct packed {
        logic sclk;
        logic cs_b;
        logic si;
    } spi_pins_type;

    typedef struct packed {
        spi_pins_type s1;
        spi_pins_type s2;
        logic sclk_d;
        logic cs_d;
        phase_type phase;
        op_type op;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [5:0] bitcnt;
        logic [7:0] shin;
        logic [7:0] shout;
        logic [2:0] obit;
        logic so;
        logic so_oe;
        logic prog_any;
        logic arm;
        flash_status_type status;
        logic [19:0] timer;
        logic [8:0] walk;
        logic resume_op;
        logic abort_op;
        logic [7:0] cont;
        logic [2:0] wrap;
        logic mem_we;
        logic [10:0] mem_addr;
        logic [7:0] mem_wdata;
    } state_type;

endpackage

// [core/secreg_store.sv]
`timescale 1ns/100ps
`include "secreg_consts.svh"
module secreg_store (
    input wire logic clk_sys,
    input wire logic clk_en,
    input wire logic we,
    input wire logic [10:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    // Three registers back to back; index bits [10:9] pick the register
    logic [7:0] mem [0:`SECREG_COUNT*`SECREG_BYTES-1];

    // One-cycle read; a write returns the old byte in the same cycle
    always_ff @(posedge clk_sys) begin
        if (clk_en) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule

// [core/flash_secreg_resume_reset.sv]
`timescale 1ns/100ps
`include "secreg_consts.svh"
// Contract
// - Status and reset commands accepted during suspend
// - Resume only when suspended and not busy
// - Resume clears suspend, sets busy quickly
// - Otherwise resume is silently ignored
// - Resume ignored after power-lost suspend
// - Three separate 512-byte security registers
// - Erase needs write enable, opcode, address
// - Address selects register, byte offset low
// - Erase runs only if frame ends exactly
// - Erase busy, then busy and enable clear
// - Locked register ignores erase and program
// - Program needs write enable, up to 256
// - Read: opcode, address, dummies on rises
// - Read data MSB first on falls
// - Read address wraps FFh to 00h
// - Read ignored while write in progress
// - Reset needs arm then reset, back-to-back
// - Reset clears volatile state, aborts operations
// - All instructions refused during reset recovery
// - Program suspend bit 15, erase bit 10
module flash_secreg_resume_reset
    import flash_pkg::*;
#(
    parameter int ERASE_CYCLES = `SECREG_ERASE_CYC,
    parameter int PROG_CYCLES = `SECREG_PROG_CYC,
    parameter int RESET_CYCLES = `RESET_RECOVERY_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic [2:0] otp_lock_bits,
    input wire logic suspend_settling,
    input wire logic suspend_power_lost,
    input wire logic array_start,
    input wire logic array_done,
    input wire logic array_suspend_program,
    input wire logic array_suspend_erase,
    input wire logic mode_load,
    input wire logic [7:0] mode_cont,
    input wire logic [2:0] mode_wrap,
    output flash_status_type status,
    output logic resume_op,
    output logic abort_op,
    output logic [7:0] continuous_read_bits,
    output logic [2:0] wrap_setting_bits
);
    state_type st;
    state_type next_st;
    logic [7:0] mem_rdata;

    // Register number 1..3, or 0 when the address names no register
    function automatic logic [1:0] secreg_sel(input logic [23:0] a);
        logic [3:0] f;
        f = a[`ADDR_SEL_MSB:`ADDR_SEL_LSB];
        secreg_sel = 2'h0;
        if (a[`ADDR_TOP_MSB:`ADDR_TOP_LSB] == 8'h00 &&
            a[`ADDR_GAP_MSB:`ADDR_GAP_LSB] == 3'h0 &&
            f >= `SECREG_FIRST && f <= `SECREG_LAST) begin
            secreg_sel = f[1:0];
        end
    endfunction

    // Which opcodes may start given busy and suspend-settling state
    function automatic logic cmd_allowed(
        input logic [7:0] op,
        input logic busy,
        input logic settling
    );
        cmd_allowed = 1'b0;
        case (op)
            `CMD_STATUS_LO, `CMD_STATUS_HI, `CMD_STATUS_INT,
            `CMD_RESET_ARM, `CMD_RESET_GO: begin
                cmd_allowed = 1'b1;
            end
            `CMD_RESUME, `CMD_WRITE_OFF: begin
                cmd_allowed = !settling;
            end
            `CMD_WRITE_ON, `CMD_SEC_ERASE, `CMD_SEC_PROG, `CMD_SEC_READ: begin
                cmd_allowed = !settling && !busy;
            end
            default: begin
                cmd_allowed = 1'b0;
            end
        endcase
    endfunction

    // Sixteen-bit status word; low byte on one read, high on the other
    function automatic logic [15:0] status_word(
        input flash_status_type s,
        input logic [2:0] lock
    );
        status_word = 16'h0000;
        status_word[`STAT_WIP] = s.write_in_progress;
        status_word[`STAT_WEL] = s.write_enable_latch;
        status_word[`STAT_LOCK_LSB +: 3] = lock;
        status_word[`STAT_ERASE_SUS] = s.erase_suspended_flag;
        status_word[`STAT_PROG_SUS] = s.program_suspended_flag;
    endfunction

    // Security register storage, one array for all three
    secreg_store store (
        .clk_sys(clk_sys),
        .clk_en(clk_en),
        .we(st.mem_we),
        .addr(st.mem_addr),
        .wdata(st.mem_wdata),
        .rdata(mem_rdata)
    );

    always_comb begin
        logic rise;
        logic fall;
        logic cs_rise;
        logic cs_fall;
        logic [7:0] op_now;
        logic [23:0] addr_now;
        logic [1:0] sel;
        logic [7:0] out_byte;
        logic [15:0] sw;
        logic out_now;
        rise = st.s2.sclk & ~st.sclk_d;
        fall = ~st.s2.sclk & st.sclk_d;
        cs_rise = st.s2.cs_b & ~st.cs_d;
        cs_fall = ~st.s2.cs_b & st.cs_d;
        op_now = {st.opcode[6:0], st.s2.si};
        addr_now = {st.addr[22:0], st.s2.si};
        sel = secreg_sel(addr_now);
        sw = status_word(st.status, otp_lock_bits);
        out_byte = 8'h00;
        out_now = 1'b0;
        next_st = st;
        next_st.resume_op = 1'b0;
        next_st.abort_op = 1'b0;
        next_st.mem_we = 1'b0;

        // Pins cross in through two flops; edges read only the second stage
        next_st.s1 = '{sclk: sclk, cs_b: cs_b, si: si};
        next_st.s2 = st.s1;
        next_st.sclk_d = st.s2.sclk;
        next_st.cs_d = st.s2.cs_b;

        // Mode bits are owned elsewhere; only reset clears them here
        if (mode_load) begin
            next_st.cont = mode_cont;
            next_st.wrap = mode_wrap;
        end

        // Step the byte address after a programmed byte is written
        if (st.mem_we && st.op == OP_NONE) begin
            next_st.mem_addr[7:0] = st.mem_addr[7:0] + 8'h01;
        end

        // Array clears go first, so a flag a command raises this cycle survives them
        if (array_done || array_suspend_program || array_suspend_erase) begin
            next_st.status.write_in_progress = 1'b0;
            next_st.status.write_enable_latch = 1'b0;
        end

        // Self-timed work runs beside the serial frame
        unique case (st.op)
            OP_NONE: begin
            end
            OP_WALK: begin
                next_st.mem_we = 1'b1;
                next_st.mem_addr = {st.mem_addr[10:9], st.walk};
                next_st.mem_wdata = `ERASED_BYTE;
                next_st.walk = st.walk + 9'h001;
                if (st.walk == 9'h1FF) begin
                    next_st.op = OP_WAIT;
                    next_st.timer = 20'(ERASE_CYCLES);
                end
            end
            OP_WAIT: begin
                if (st.timer == 20'h00000) begin
                    next_st.op = OP_NONE;
                    next_st.status.write_in_progress = 1'b0;
                    next_st.status.write_enable_latch = 1'b0;
                end else begin
                    next_st.timer = st.timer - 20'h00001;
                end
            end
            OP_RECOVER: begin
                if (st.timer == 20'h00000) begin
                    next_st.op = OP_NONE;
                end else begin
                    next_st.timer = st.timer - 20'h00001;
                end
            end
        endcase

        // Frame start: nothing is taken while recovering from reset
        if (cs_fall) begin
            next_st.phase = (st.op == OP_RECOVER) ? PH_SKIP : PH_CMD;
            next_st.bitcnt = 6'h00;
            next_st.obit = 3'h0;
            next_st.prog_any = 1'b0;
        end else if (cs_rise) begin
            next_st.phase = PH_IDLE;
            next_st.so_oe = 1'b0;
            next_st.so = 1'b0;
            // Commands that act on the end of the frame
            if (st.phase == PH_CMD || st.phase == PH_ADDR || st.phase == PH_DATA) begin
                case (st.opcode)
                    `CMD_RESET_ARM: begin
                        if (st.bitcnt == `OPCODE_BITS) begin
                            next_st.arm = 1'b1;
                        end
                    end
                    `CMD_RESET_GO: begin
                        next_st.arm = 1'b0;
                        if (st.bitcnt == `OPCODE_BITS && st.arm) begin
                            next_st.status = '0;
                            next_st.cont = 8'h00;
                            next_st.wrap = 3'h0;
                            next_st.abort_op = 1'b1;
                            next_st.op = OP_RECOVER;
                            next_st.timer = 20'(RESET_CYCLES);
                        end
                    end
                    `CMD_RESUME: begin
                        // Busy is raised on the very next clock, well inside 200 ns
                        if (st.bitcnt == `OPCODE_BITS && st.status.suspend_flag &&
                            !st.status.write_in_progress &&
                            !suspend_power_lost) begin
                            next_st.status.program_suspended_flag = 1'b0;
                            next_st.status.erase_suspended_flag = 1'b0;
                            next_st.status.write_in_progress = 1'b1;
                            next_st.resume_op = 1'b1;
                        end
                    end
                    `CMD_WRITE_ON: begin
                        if (st.bitcnt == `OPCODE_BITS) begin
                            next_st.status.write_enable_latch = 1'b1;
                        end
                    end
                    `CMD_WRITE_OFF: begin
                        if (st.bitcnt == `OPCODE_BITS) begin
                            next_st.status.write_enable_latch = 1'b0;
                        end
                    end
                    `CMD_SEC_ERASE: begin
                        if (st.bitcnt == `ADDR_END_BITS && st.phase == PH_DATA) begin
                            next_st.op = OP_WALK;
                            next_st.walk = 9'h000;
                            next_st.status.write_in_progress = 1'b1;
                        end
                    end
                    `CMD_SEC_PROG: begin
                        // A partial last byte is dropped; whole bytes are kept
                        if (st.prog_any) begin
                            next_st.op = OP_WAIT;
                            next_st.timer = 20'(PROG_CYCLES);
                            next_st.status.write_in_progress = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (rise && st.phase != PH_IDLE && st.phase != PH_SKIP) begin
            // Every input bit is taken on a serial-clock rise
            if (st.bitcnt != `BITCNT_MAX) begin
                next_st.bitcnt = st.bitcnt + 6'h01;
            end
            unique case (st.phase)
                PH_CMD: begin
                    next_st.opcode = op_now;
                    if (st.bitcnt == `OPCODE_BITS - 6'h01) begin
                        if (op_now != `CMD_RESET_GO) begin
                            next_st.arm = 1'b0;
                        end
                        if (!cmd_allowed(op_now, st.status.write_in_progress,
                                         suspend_settling)) begin
                            next_st.phase = PH_SKIP;
                        end else if (op_now == `CMD_SEC_ERASE ||
                                     op_now == `CMD_SEC_PROG) begin
                            // Write enable must already be set
                            next_st.phase = st.status.write_enable_latch ?
                                            PH_ADDR : PH_SKIP;
                        end else if (op_now == `CMD_SEC_READ) begin
                            next_st.phase = PH_ADDR;
                        end else begin
                            next_st.phase = PH_DATA;
                        end
                    end
                end
                PH_ADDR: begin
                    next_st.addr = addr_now;
                    if (st.bitcnt == `ADDR_END_BITS - 6'h01) begin
                        next_st.mem_addr = {sel - 2'h1, addr_now[8:0]};
                        if (sel == 2'h0) begin
                            next_st.phase = PH_SKIP;
                        end else if (st.opcode != `CMD_SEC_READ &&
                                     otp_lock_bits[sel - 2'h1]) begin
                            next_st.phase = PH_SKIP;
                        end else begin
                            next_st.phase = PH_DATA;
                        end
                    end
                end
                PH_DATA: begin
                    if (st.opcode == `CMD_SEC_PROG) begin
                        next_st.shin = {st.shin[6:0], st.s2.si};
                        next_st.obit = st.obit + 3'h1;
                        if (st.obit == 3'h7) begin
                            // Programming can only clear bits of the stored byte
                            next_st.mem_we = 1'b1;
                            next_st.mem_wdata = mem_rdata & {st.shin[6:0], st.s2.si};
                            next_st.prog_any = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (fall && st.phase == PH_DATA) begin
            // Output bits change on serial-clock falls, MSB first
            if (st.opcode == `CMD_STATUS_LO) begin
                out_now = 1'b1;
                out_byte = sw[7:0];
            end else if (st.opcode == `CMD_STATUS_HI) begin
                out_now = 1'b1;
                out_byte = sw[15:8];
            end else if (st.opcode == `CMD_SEC_READ &&
                         st.bitcnt >= `READ_DATA_BITS) begin
                out_now = 1'b1;
                out_byte = mem_rdata;
            end
            if (out_now) begin
                next_st.so_oe = 1'b1;
                next_st.obit = st.obit + 3'h1;
                if (st.obit == 3'h0) begin
                    next_st.so = out_byte[7];
                    next_st.shout = {out_byte[6:0], 1'b0};
                    if (st.opcode == `CMD_SEC_READ) begin
                        next_st.mem_addr[7:0] = st.mem_addr[7:0] + 8'h01;
                    end
                end else begin
                    next_st.so = st.shout[7];
                    next_st.shout = {st.shout[6:0], 1'b0};
                end
            end
        end

        // Array sets come last so they beat a same-cycle clear by a command
        if (array_start) begin
            next_st.status.write_in_progress = 1'b1;
        end
        if (array_suspend_program) begin
            next_st.status.program_suspended_flag = 1'b1;
        end
        if (array_suspend_erase) begin
            next_st.status.erase_suspended_flag = 1'b1;
        end
        next_st.status.suspend_flag = next_st.status.program_suspended_flag |
                                      next_st.status.erase_suspended_flag;
    end

    // All state in one register; chip select rests high after reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.phase <= PH_IDLE;
            st.op <= OP_NONE;
            st.s1.cs_b <= 1'b1;
            st.s2.cs_b <= 1'b1;
            st.cs_d <= 1'b1;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign so = st.so;
    assign so_oe = st.so_oe;
    assign status = st.status;
    assign resume_op = st.resume_op;
    assign abort_op = st.abort_op;
    assign continuous_read_bits = st.cont;
    assign wrap_setting_bits = st.wrap;
endmodule

// [sim/flash_chk.sv]
`timescale 1ns/100ps
module flash_chk
    import flash_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic so_oe,
    input wire logic suspend_power_lost,
    input wire flash_status_type status,
    input wire logic resume_op,
    input wire logic abort_op,
    input wire logic [7:0] continuous_read_bits,
    input wire logic [2:0] wrap_setting_bits
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Select high long enough to pass the pin synchroniser
    sequence s_deselected;
        cs_b [*5];
    endsequence
    // Nothing may answer in the first 8 cycles of the reset recovery
    sequence s_quiet;
        (!so_oe && !resume_op) [*8];
    endsequence
    a_resume_sets_busy: assert property (
        resume_op |-> status.write_in_progress && !status.suspend_flag)
        else $error("resume left flags wrong");
    a_resume_when_ok: assert property (
        resume_op |-> $past(status.suspend_flag) && !$past(status.write_in_progress))
        else $error("resume taken in wrong state");
    a_resume_power_ok: assert property (
        resume_op |-> !$past(suspend_power_lost)) else $error("resume after power loss");
    a_resume_one_pulse: assert property (
        resume_op |=> !resume_op) else $error("resume pulse too long");
    a_reset_clears_all: assert property (
        abort_op |-> status == '0 && continuous_read_bits == 8'h00
        && wrap_setting_bits == 3'h0) else $error("reset left state");
    a_recovery_refuses: assert property (
        abort_op |=> s_quiet) else $error("answer during recovery");
    a_suspend_merge: assert property (
        status.suspend_flag == (status.program_suspended_flag || status.erase_suspended_flag))
        else $error("suspend flag mismatch");
    a_busy_end_wel: assert property (
        $fell(status.write_in_progress) |-> !status.write_enable_latch)
        else $error("enable latch kept after busy");
    a_idle_no_drive: assert property (
        s_deselected |-> !so_oe) else $error("output driven while deselected");
endmodule
bind flash_secreg_resume_reset flash_chk chk (.clk_sys, .rst_b, .cs_b, .so_oe,
    .suspend_power_lost, .status, .resume_op, .abort_op, .continuous_read_bits,
    .wrap_setting_bits);

// [sim/spi_host.sv]
`timescale 1ns/100ps
module spi_host (
    output logic sclk,
    output logic cs_b,
    output logic si,
    input wire logic so,
    output logic [7:0] rx,
    output logic got
);
    // Idle pins at time zero; clock rests low outside frames
    initial begin
        sclk = 0;
        cs_b = 1;
        si = 0;
        rx = 0;
        got = 0;
    end
    // One whole frame: send ntx bits, then clock in nrx bytes
    task xfer(input logic [63:0] tx, input int ntx, input int nrx);
        int i;
        cs_b = 0;
        #60;
        for (i = ntx - 1; i >= 0; i--) begin
            si = tx[i];
            #62.5 sclk = 1;
            #62.5 sclk = 0;
        end
        for (i = 0; i < nrx * 8; i++) begin
            #62.5 sclk = 1;
            rx = {rx[6:0], so};
            #62.5 sclk = 0;
            if (i % 8 == 7) begin
                got = 1;
                #1 got = 0;
            end
        end
        #60 cs_b = 1;
        si = ~si; // Deselected: no stale level for the device to lean on
        #500;
    endtask
endmodule

// [sim/testbench.sv]
`timescale 1ns/100ps
module testbench
    import flash_pkg::*;
;
    logic clk_sys, rst_b, clk_en, sclk, cs_b, si, so, so_oe, suspend_settling;
    logic suspend_power_lost, array_start, array_done, array_suspend_program;
    logic array_suspend_erase, mode_load, resume_op, abort_op, got;
    logic [2:0] otp_lock_bits, mode_wrap, wrap_setting_bits;
    logic [7:0] mode_cont, continuous_read_bits, rx, d0, d1;
    flash_status_type status;
    logic [7:0] expq[$];
    logic [31:0] seed = 32'hF144D664;
    int err_total, comparisons, cyc, k;
    flash_secreg_resume_reset #(.ERASE_CYCLES(1200), .PROG_CYCLES(20), .RESET_CYCLES(200)) dut (
        .clk_sys, .rst_b, .clk_en, .sclk, .cs_b, .si, .so, .so_oe, .otp_lock_bits,
        .suspend_settling, .suspend_power_lost, .array_start, .array_done,
        .array_suspend_program, .array_suspend_erase, .mode_load, .mode_cont, .mode_wrap,
        .status, .resume_op, .abort_op, .continuous_read_bits, .wrap_setting_bits);
    spi_host host (.sclk, .cs_b, .si, .so, .rx, .got);
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task check(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task report_and_stop;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task step;
        @(posedge clk_sys);
        #1;
    endtask
    // Status read: note the expected byte, then clock it out
    task stat(input logic [7:0] op, input logic [7:0] e);
        expq.push_back(e);
        host.xfer(64'(op), 8, 1);
    endtask
    task fin(input string s);
        $display("test %s done", s);
    endtask
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Every byte the host clocks in is matched to the oldest note
    always @(posedge got) begin
        check(rx, expq.size() ? expq.pop_front() : 8'hXX);
    end
    // Hang guard, well above the length of the sequence below
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            report_and_stop;
        end
    end
    initial begin
        {rst_b, suspend_settling, suspend_power_lost, array_start, array_done} = 5'h00;
        {array_suspend_program, array_suspend_erase, mode_load, mode_cont, mode_wrap} = 14'h0000;
        clk_en = 1;
        otp_lock_bits = 3'h4;
        repeat (16) step;
        rst_b = 1;
        repeat (4) step;
        stat(8'h05, 8'h00);
        stat(8'h35, 8'h20);
        host.xfer(64'h06, 8, 0);
        host.xfer(64'h44001000, 32, 0);
        expq.push_back(8'h00);
        host.xfer({24'h0, 8'h48, 24'h001000, 8'h00}, 40, 1);
        stat(8'h05, 8'h03);
        repeat (700) step;
        stat(8'h05, 8'h00);
        fin("erase");
        d0 = 8'(xs());
        d1 = 8'(xs());
        host.xfer(64'h06, 8, 0);
        host.xfer({16'h0, 8'h42, 24'h0010FF, d0, d1}, 48, 0);
        repeat (100) step;
        expq.push_back(d0);
        expq.push_back(d1);
        host.xfer({24'h0, 8'h48, 24'h0010FF, 8'h00}, 40, 2);
        fin("program read");
        host.xfer(64'h06, 8, 0);
        host.xfer(64'h44003000, 32, 0);
        host.xfer(64'h44004000, 32, 0);
        host.xfer(64'h88002000, 33, 0);
        stat(8'h05, 8'h02);
        fin("refused");
        for (k = 0; k < 2; k++) begin
            step;
            array_start = 1;
            step;
            array_start = 0;
            {array_suspend_erase, array_suspend_program} = k ? 2'h2 : 2'h1; // Program suspend on the first pass, erase suspend on the second
            step;
            {array_suspend_erase, array_suspend_program} = 2'h0;
            suspend_settling = 1;
            stat(8'h05, 8'h00);
            stat(8'h35, k ? 8'h24 : 8'hA0);
            step;
            suspend_settling = 0;
            suspend_power_lost = 1;
            host.xfer(64'h7A, 8, 0);
            stat(8'h35, k ? 8'h24 : 8'hA0);
            step;
            suspend_power_lost = 0;
            host.xfer(64'h7A, 8, 0);
            stat(8'h05, 8'h01);
            host.xfer(64'h7A, 8, 0);
            stat(8'h35, 8'h20);
            step;
            array_done = 1;
            step;
            array_done = 0;
            fin("suspend resume");
        end
        {mode_cont, mode_wrap} = 11'(xs()) | 11'h401; // Nonzero so the reset clear shows
        mode_load = 1;
        step;
        mode_load = 0;
        step;
        check(continuous_read_bits, mode_cont);
        check({5'h00, wrap_setting_bits}, {5'h00, mode_wrap});
        host.xfer(64'h06, 8, 0);
        host.xfer(64'h66, 8, 0);
        stat(8'h05, 8'h02);
        host.xfer(64'h99, 8, 0);
        stat(8'h05, 8'h02);
        host.xfer(64'h66, 8, 0);
        host.xfer(64'h99, 8, 0);
        host.xfer(64'h06, 8, 0);
        repeat (40) step;
        stat(8'h05, 8'h00);
        check({5'h00, wrap_setting_bits}, 8'h00);
        check(continuous_read_bits, 8'h00);
        fin("reset");
        report_and_stop;
    end
endmodule
